// ### design/rxis_pkg.sv
/*
 * Shared constants and types of the receive interrupt mask and summary block.
 * Assumes a byte-wide register file behind a 32-bit Avalon-MM slave.
 */
`default_nettype none
package rxis_pkg;
	// Bus geometry
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;

	// Register indices, byte address is four times the index
	localparam logic [7:0] IDX_SPARE_LO = 8'h9c;
	localparam logic [7:0] IDX_SPARE_HI = 8'h9d;
	localparam logic [7:0] IDX_SUMMARY  = 8'h9f;
	localparam logic [7:0] IDX_MASK1    = 8'ha0;
	localparam logic [7:0] IDX_MASK2    = 8'ha1;
	localparam logic [7:0] IDX_MASK3    = 8'ha2;
	localparam logic [7:0] IDX_CTRL     = 8'hb0;

	// Reset values
	localparam logic [7:0] RST_MASK  = 8'h00;
	localparam logic [7:0] RST_SPARE = 8'h00;
	localparam logic [7:0] RST_CTRL  = 8'h00;
	localparam logic [7:0] RST_RDATA = 8'h00;

	// Implemented mask bits
	localparam logic [7:0] MASK2_USED    = 8'h0f;
	localparam logic [7:0] MASK3_E1_USED = 8'hbb;

	// Control register fields
	localparam int CTRL_E1_BIT  = 0;
	localparam int CTRL_LEN_LSB = 4;
	localparam int CTRL_LEN_W   = 4;

	// Summary bit positions
	localparam int SUM_G2 = 1;
	localparam int SUM_G6 = 5;
	localparam int SUM_B7 = 7;

	// Spare pattern: lengths up to this use the low byte only
	localparam logic [4:0] SPARE_SPLIT_LEN = 5'd7;
	localparam logic [4:0] SPARE_MAX_LEN   = 5'd16;

	// Latched status groups 1 to 7, one byte each
	typedef struct packed {
		logic [7:1][7:0] grp;
	} rxis_groups_t;

	// Masks of groups 4 to 7, held outside this block
	typedef struct packed {
		logic [7:4][7:0] grp;
	} rxis_ext_mask_t;

	// Bus slave states, one-hot
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} rxis_bus_st_t;

	// Spare comparator state
	typedef struct packed {
		logic [15:0] hist;
		logic [4:0]  fill;
		logic        match;
	} rxis_spare_st_t;
endpackage
`default_nettype wire

// ### design/rxis_spare_match.sv
/*
 * Spare-code comparator over the received bit stream.
 * Assumes one received bit per enable pulse, synchronous to clk_sys_i.
 */
`timescale 1ns/1ns
`default_nettype none
module rxis_spare_match
	import rxis_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       reset_n_i,
	// Received stream
	input  wire logic       rx_bit_i,
	input  wire logic       rx_bit_en_i,
	input  wire logic       restart_i,
	// Pattern definition
	input  wire logic [7:0] pattern_lo_i,
	input  wire logic [7:0] pattern_hi_i,
	input  wire logic [3:0] len_code_i,
	// Result
	output logic            match_o
);
	rxis_spare_st_t s_ff;
	rxis_spare_st_t nxt_s;

	// Shift history, compare last len bits to pattern head
	always_comb begin
		logic [4:0]  len;
		logic [15:0] pat;
		logic        ok;
		len = {1'b0, len_code_i} + 5'd1;
		pat = {pattern_lo_i, pattern_hi_i}; // R11
		ok = 1'b1;
		nxt_s = s_ff;
		if (len <= SPARE_SPLIT_LEN) begin
			pat[7:0] = 8'h00; // R10
		end
		if (restart_i) begin
			nxt_s.hist = 16'h0000;
			nxt_s.fill = 5'd0;
			nxt_s.match = 1'b0;
		end else if (rx_bit_en_i) begin
			nxt_s.hist = {s_ff.hist[14:0], rx_bit_i};
			if (s_ff.fill < SPARE_MAX_LEN) begin
				nxt_s.fill = s_ff.fill + 5'd1;
			end
			for (int i = 0; i < 16; i++) begin
				if (i < int'(len)) begin
					if (nxt_s.hist[int'(len) - 1 - i] != pat[15 - i]) begin
						ok = 1'b0; // R11
					end
				end
			end
			nxt_s.match = ok && (nxt_s.fill >= len);
		end
	end

	// State register
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign match_o = s_ff.match;
endmodule // rxis_spare_match
`default_nettype wire

// ### design/rxis_top.sv
/*
 * Receive interrupt masking and source summary with its Avalon-MM slave.
 * Assumes latched status groups and the masks of groups 4 to 7 come from
 * neighbouring logic on the same clock; all inputs are synchronous.
 */
// Chosen here: the Avalon-MM register port.
//
// Behaviour
// R01 - Summary bits 6..0 flag groups 7..1 pending; bit 7 reads zero
// R02 - Summary bit clears itself once no unmasked event remains in group
// R03 - Masked status bits never reach the summary
// R04 - Group 2 summary bit held zero in T1 mode
// R05 - Group 6 summary bit reserved, reads zero
// R06 - Mask bit zero blocks, one allows; all masks reset to zero
// R07 - Mask 1: bits 7..4 alarm clears, bits 3..0 alarm detects
// R08 - Mask 2 for E1 events in bits 3..0; bits 7..4 unused
// R09 - Mask 3 in T1: clock loss, spare, loop-down, loop-up clear/detect
// R10 - Second spare byte ignored for pattern lengths of seven or fewer
// R11 - First spare byte bit 7 is first pattern bit, then descending
// R12 - Active-low interrupt asserts when an enabled latched event is set
// R13 - In E1 mode mask 3 has bits 6 and 2 unused
// R14 - Summary is a combinational OR of status AND mask per group
`timescale 1ns/1ns
`default_nettype none
module rxis_top
	import rxis_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              reset_n_i,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0] avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [DATA_W-1:0] avs_writedata_i,
	input  wire logic [3:0]        avs_byteenable_i,
	output logic      [DATA_W-1:0] avs_readdata_o,
	output logic                   avs_waitrequest_o,
	// Latched status and outside masks
	input  wire rxis_groups_t      status_i,
	input  wire rxis_ext_mask_t    ext_mask_i,
	// Received stream for the spare comparator
	input  wire logic              rx_bit_i,
	input  wire logic              rx_bit_en_i,
	// Results
	output logic                   irq_out_n_o,
	output logic                   spare_code_match_o
);
	// Register state of the block, apart from the spare comparator's own state in u_spare
	typedef struct packed {
		rxis_bus_st_t bus;
		logic         wait_n;
		logic [7:0]   rdata;
		logic [7:0]   mask1;
		logic [7:0]   mask2;
		logic [7:0]   mask3;
		logic [7:0]   spare_lo;
		logic [7:0]   spare_hi;
		logic [7:0]   ctrl;
		logic         irq_n;
		logic         restart;
	} rxis_state_t;

	rxis_state_t     s_ff;
	rxis_state_t     nxt_s;
	logic [7:1][7:0] eff_mask;
	logic [7:1]      pend;
	logic [7:0]      summary;
	logic            e1_mode;
	logic [7:0]      req_idx;
	logic            req_ok;
	logic            spare_match;

	// Any enabled event in one group
	function automatic logic any_enabled(input logic [7:0] stat,
	                                     input logic [7:0] mask);
		any_enabled = |(stat & mask);
	endfunction

	// Register index of a byte address
	function automatic logic [7:0] addr_index(input logic [ADDR_W-1:0] a);
		addr_index = a[ADDR_W-1:2];
	endfunction

	assign e1_mode = s_ff.ctrl[CTRL_E1_BIT];
	assign req_idx = addr_index(avs_address_i);
	assign req_ok  = (avs_address_i[1:0] == 2'b00);

	// Effective masks per group
	always_comb begin
		eff_mask[1] = s_ff.mask1; // R07
		eff_mask[2] = s_ff.mask2 & MASK2_USED; // R08
		if (e1_mode) begin
			eff_mask[3] = s_ff.mask3 & MASK3_E1_USED; // R13
		end else begin
			eff_mask[3] = s_ff.mask3; // R09
		end
		eff_mask[4] = ext_mask_i.grp[4];
		eff_mask[5] = ext_mask_i.grp[5];
		eff_mask[6] = ext_mask_i.grp[6];
		eff_mask[7] = ext_mask_i.grp[7];
	end

	// Pending flag of each group, masked bits drop out
	genvar g;
	generate
		for (g = 1; g <= 7; g++) begin : gen_pend
			assign pend[g] = any_enabled(status_i.grp[g], eff_mask[g]); // R03 R14 R06
		end
	endgenerate

	// Summary follows the group flags, so it clears with them
	always_comb begin
		summary = {1'b0, pend}; // R01 R02 R14
		summary[SUM_B7] = 1'b0; // R01
		summary[SUM_G6] = 1'b0; // R05
		if (!e1_mode) begin
			summary[SUM_G2] = 1'b0; // R04
		end
	end

	// Read multiplexer
	function automatic logic [7:0] read_reg(input rxis_state_t st,
	                                        input logic [7:0] idx,
	                                        input logic [7:0] sum);
		case (idx)
			IDX_SPARE_LO: read_reg = st.spare_lo;
			IDX_SPARE_HI: read_reg = st.spare_hi;
			IDX_SUMMARY:  read_reg = sum;
			IDX_MASK1:    read_reg = st.mask1;
			IDX_MASK2:    read_reg = st.mask2;
			IDX_MASK3:    read_reg = st.mask3;
			IDX_CTRL:     read_reg = st.ctrl;
			default:      read_reg = RST_RDATA;
		endcase
	endfunction

	// Bus handshake, register writes and interrupt output
	always_comb begin
		nxt_s = s_ff;
		nxt_s.restart = 1'b0;
		case (s_ff.bus)
			BUS_IDLE: begin
				nxt_s.wait_n = 1'b0;
				if (avs_read_i || avs_write_i) begin
					nxt_s.bus = BUS_ACK;
					nxt_s.wait_n = 1'b1;
					if (avs_read_i && req_ok) begin
						nxt_s.rdata = read_reg(s_ff, req_idx, summary);
					end else begin
						nxt_s.rdata = RST_RDATA;
					end
				end
			end
			BUS_ACK: begin
				// Write lands at the edge the master sees waitrequest low
				nxt_s.bus = BUS_IDLE;
				nxt_s.wait_n = 1'b0;
				if (avs_write_i && req_ok && avs_byteenable_i[0]) begin
					case (req_idx)
						IDX_SPARE_LO: begin
							nxt_s.spare_lo = avs_writedata_i[7:0];
							nxt_s.restart = 1'b1;
						end
						IDX_SPARE_HI: nxt_s.spare_hi = avs_writedata_i[7:0];
						IDX_MASK1:    nxt_s.mask1 = avs_writedata_i[7:0]; // R07
						IDX_MASK2:    nxt_s.mask2 = avs_writedata_i[7:0]; // R08
						IDX_MASK3:    nxt_s.mask3 = avs_writedata_i[7:0]; // R09
						IDX_CTRL:     nxt_s.ctrl = avs_writedata_i[7:0];
						default:      nxt_s.ctrl = s_ff.ctrl;
					endcase
				end
			end
			default: begin
				nxt_s.bus = BUS_IDLE;
				nxt_s.wait_n = 1'b0;
			end
		endcase
		// Active low while any summary bit is set
		nxt_s.irq_n = ~|summary; // R12
	end

	// State register, masks start cleared
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_ff.bus      <= BUS_IDLE;
			s_ff.wait_n   <= 1'b0;
			s_ff.rdata    <= RST_RDATA;
			s_ff.mask1    <= RST_MASK; // R06
			s_ff.mask2    <= RST_MASK; // R06
			s_ff.mask3    <= RST_MASK; // R06
			s_ff.spare_lo <= RST_SPARE;
			s_ff.spare_hi <= RST_SPARE;
			s_ff.ctrl     <= RST_CTRL;
			s_ff.irq_n    <= 1'b1;
			s_ff.restart  <= 1'b0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Spare comparator, T1 only
	rxis_spare_match u_spare (
		.clk_sys_i    (clk_sys_i),
		.reset_n_i    (reset_n_i),
		.rx_bit_i     (rx_bit_i),
		.rx_bit_en_i  (rx_bit_en_i && !e1_mode),
		.restart_i    (s_ff.restart || e1_mode),
		.pattern_lo_i (s_ff.spare_lo),
		.pattern_hi_i (s_ff.spare_hi), // R10
		.len_code_i   (s_ff.ctrl[CTRL_LEN_LSB +: CTRL_LEN_W]),
		.match_o      (spare_match)
	);

	// Outputs straight from flip-flops
	assign avs_readdata_o     = {24'h000000, s_ff.rdata};
	assign avs_waitrequest_o  = ~s_ff.wait_n;
	assign irq_out_n_o        = s_ff.irq_n;
	assign spare_code_match_o = spare_match;
endmodule // rxis_top
`default_nettype wire

// ### tb/rxis_host_bfm.sv
/* Host model: Avalon-MM master reaching the block's byte registers.
   Assumes a slave that drops waitrequest for one cycle per access. */
`timescale 1ns/1ns
`default_nettype none
module rxis_host_bfm
	import rxis_pkg::*;
(
	// Clock
	input  wire logic              clk_sys_i,
	// Avalon-MM master side
	output logic      [ADDR_W-1:0] avs_address_o,
	output logic                   avs_read_o,
	output logic                   avs_write_o,
	output logic      [DATA_W-1:0] avs_writedata_o,
	output logic      [3:0]        avs_byteenable_o,
	input  wire logic [DATA_W-1:0] avs_readdata_i,
	input  wire logic              avs_waitrequest_i
);
	// Idle bus at time zero
	initial begin
		avs_address_o = '0;
		avs_read_o = 1'b0;
		avs_write_o = 1'b0;
		avs_writedata_o = '0;
		avs_byteenable_o = 4'hf;
	end
	// One access, held until waitrequest is sampled low
	task automatic acc(input logic [9:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_sys_i);
		avs_address_o <= a;
		avs_read_o <= !w;
		avs_write_o <= w;
		avs_writedata_o <= {24'h0, d};
		// Only the bench's hang guard ends a wait that never answers
		do begin
			@(posedge clk_sys_i);
		end while (avs_waitrequest_i !== 1'b0);
		q = avs_readdata_i[7:0];
		avs_read_o <= 1'b0;
		avs_write_o <= 1'b0;
		avs_address_o <= ~a; // Released lines do not keep old values
		avs_writedata_o <= ~avs_writedata_o;
	endtask
endmodule // rxis_host_bfm
`default_nettype wire

// ### tb/rxis_top_properties.sv
/* Port-level checks of the receive interrupt summary block.
   Assumes one clock and the asynchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module rxis_checker
	import rxis_pkg::*;
(
	// Clock, reset and bus
	input wire logic              clk_sys_i,
	input wire logic              reset_n_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic              avs_read_i,
	input wire logic              avs_write_i,
	input wire logic [DATA_W-1:0] avs_readdata_o,
	input wire logic              avs_waitrequest_o,
	// Status and results
	input wire rxis_groups_t      status_i,
	input wire logic              rx_bit_en_i,
	input wire logic              irq_out_n_o,
	input wire logic              spare_code_match_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
	AST_ANSWER_NEXT: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("no answer");
	AST_RDATA_UPPER: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_IRQ_QUIET: assert property (status_i == '0 |=> irq_out_n_o)
		else $error("irq without status");
	AST_IRQ_SUMMARY: assert property (avs_read_i && avs_waitrequest_o
		&& avs_address_i == {IDX_SUMMARY, 2'b00} |=> irq_out_n_o == (avs_readdata_o[7:0]
		== 8'h00) && !avs_readdata_o[7] && !avs_readdata_o[5]) else $error("summary irq");
	AST_MISALIGN: assert property (avs_read_i && avs_waitrequest_o && avs_address_i[1:0]
		!= 2'b00 |=> avs_readdata_o == 32'h0) else $error("misaligned read data");
	AST_RDATA_HOLD: assert property (!avs_read_i && !avs_write_i |=> $stable(avs_readdata_o))
		else $error("read data moved");
	AST_SPARE_HOLD: assert property (!rx_bit_en_i && !avs_write_i && !$past(avs_write_i)
		&& !$past(avs_write_i, 2) |=> $stable(spare_code_match_o)) else $error("match moved");
endmodule // rxis_checker
bind rxis_top rxis_checker u_chk (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.status_i(status_i), .rx_bit_en_i(rx_bit_en_i), .irq_out_n_o(irq_out_n_o),
	.spare_code_match_o(spare_code_match_o));
`default_nettype wire

// ### tb/test_rx_interrupt_mask_and_summary.sv
/* Self-checking bench of the receive interrupt summary block.
   Assumes the host model drives the bus, mask shadows predict the summary and a queue model the spare match. */
`timescale 1ns/1ns
`default_nettype none
module test_rx_interrupt_mask_and_summary
	import rxis_pkg::*;
;
	logic clk_sys_i, reset_n_i, rx_bit_i, rx_bit_en_i, rd, wr, wrq, irq_n, sm, e1, b, ok;
	logic [ADDR_W-1:0] adr;
	logic [DATA_W-1:0] wd, rdat;
	logic [3:0] be, len;
	logic [7:0] q, mk [1:3];
	logic [15:0] pat;
	rxis_groups_t st;
	rxis_ext_mask_t ext;
	int error_cnt = 0, n_tests = 0, cyc = 0, L;
	int hist [$];
	rxis_top DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .status_i(st), .ext_mask_i(ext),
		.rx_bit_i(rx_bit_i), .rx_bit_en_i(rx_bit_en_i), .irq_out_n_o(irq_n),
		.spare_code_match_o(sm));
	rxis_host_bfm host (.clk_sys_i(clk_sys_i), .avs_address_o(adr), .avs_read_o(rd),
		.avs_write_o(wr), .avs_writedata_o(wd), .avs_byteenable_o(be),
		.avs_readdata_i(rdat), .avs_waitrequest_i(wrq));
	// Clock
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	task automatic w(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] x;
		host.acc({i, 2'b00}, 1'b1, d, x);
	endtask
	task automatic r(input logic [7:0] i);
		host.acc({i, 2'b00}, 1'b0, 8'h00, q);
	endtask
	// Expected summary from status and mask shadows
	function automatic logic [7:0] sum_exp();
		logic [7:0] s, m;
		s = 8'h00;
		for (int g = 1; g <= 7; g++) begin
			m = g == 1 ? mk[1] : g == 2 ? (e1 ? mk[2] & MASK2_USED : 8'h00) :
				g == 3 ? (e1 ? mk[3] & MASK3_E1_USED : mk[3]) : ext.grp[g];
			s[g-1] = |(st.grp[g] & m);
		end
		s[SUM_G6] = 1'b0;
		return s;
	endfunction
	// Main sequence
	initial begin
		reset_n_i = 1'b0;
		rx_bit_i = 1'b0;
		rx_bit_en_i = 1'b0;
		st = '0;
		ext = '0;
		e1 = 1'b0;
		void'($urandom(34936));
		repeat (5) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		foreach (mk[i]) begin
			r(8'(IDX_MASK1 + i - 1));
			chk(q, 8'h00);
		end
		r(IDX_SPARE_HI);
		chk(q, RST_SPARE);
		w(8'h9e, 8'h5a);
		r(8'h9e);
		chk(q, 8'h00);
		w(IDX_MASK1, 8'hff);
		host.acc(10'h281, 1'b0, 8'h00, q);
		chk(q, 8'h00);
		// Write without lane 0 enabled must not land
		host.avs_byteenable_o <= 4'he;
		w(IDX_MASK2, 8'h3c);
		host.avs_byteenable_o <= 4'hf;
		r(IDX_MASK2);
		chk(q, RST_MASK);
		$display("test reset and refusal done");
		repeat (40) begin
			e1 = 1'($urandom % 2);
			w(IDX_CTRL, {7'h0, e1});
			for (int i = 1; i <= 3; i++) begin
				mk[i] = 8'($urandom);
				w(8'(IDX_MASK1 + i - 1), mk[i]);
				r(8'(IDX_MASK1 + i - 1));
				chk(q, mk[i]);
			end
			st <= ($urandom % 4 == 0) ? '0 : 56'({$urandom, $urandom});
			ext <= $urandom;
			repeat (3) @(posedge clk_sys_i);
			chk(irq_n, sum_exp() == 8'h00);
			r(IDX_SUMMARY);
			chk(q, sum_exp());
		end
		$display("test summary done");
		w(IDX_CTRL, 8'h00);
		repeat (8) begin
			len = 4'($urandom);
			pat = 16'($urandom);
			L = len + 1;
			w(IDX_CTRL, {len, 4'h0});
			w(IDX_SPARE_HI, pat[7:0]);
			w(IDX_SPARE_LO, pat[15:8]);
			hist.delete();
			// Let the restart from the low byte write pass before the first bit
			@(posedge clk_sys_i);
			for (int k = 0; k < 40; k++) begin
				b = ($urandom % 5 == 0) ? 1'($urandom) : pat[15 - k % L];
				hist.push_back(b);
				rx_bit_i <= b;
				rx_bit_en_i <= 1'b1;
				@(posedge clk_sys_i);
				rx_bit_en_i <= 1'b0;
				@(posedge clk_sys_i);
				#1;
				ok = hist.size() >= L;
				for (int j = 0; j < L && ok; j++)
					ok = hist[hist.size() - L + j] == pat[15 - j];
				chk(sm, ok);
				@(posedge clk_sys_i);
			end
		end
		$display("test spare done");
		print_verdict();
	end
endmodule // test_rx_interrupt_mask_and_summary
`default_nettype wire
